// ---- hw/tba_pkg.sv ----
// constants and types of the two-wire addressing and status block
package tba_pkg;
	// register byte offsets, decoded on adr[4:2]
	localparam logic [4:0] OFF_CTRL   = 5'h00;
	localparam logic [4:0] OFF_STATUS = 5'h04;
	localparam logic [4:0] OFF_OWN    = 5'h08;
	localparam logic [4:0] OFF_TX     = 5'h0C;
	localparam logic [4:0] OFF_RX     = 5'h10;
	// bus_control_reg fields
	localparam int CTRL_EN    = 15;
	localparam int CTRL_TEN   = 10;
	localparam int CTRL_STOP  = 1;
	localparam int CTRL_START = 0;
	// bus_status_reg fields
	localparam int ST_TBF  = 0;
	localparam int ST_RBF  = 1;
	localparam int ST_RW   = 2;
	localparam int ST_DA   = 5;
	localparam int ST_A10  = 8;
	localparam int ST_BCL  = 10;
	localparam int ST_MEV  = 12;
	localparam int ST_SEV  = 13;
	localparam int ST_ACKS = 15;
	// reset values
	localparam logic [9:0] OWN_RST = 10'h000;
	localparam logic [7:0] BYTE_RST = 8'h00;
	// event toggles and levels from the link side
	localparam int EV_RX  = 0;
	localparam int EV_TBF = 1;
	localparam int EV_BCL = 2;
	localparam int EV_MEV = 3;
	localparam int EV_SEV = 4;
	// master bit timing in link clocks: low while q <= MQ_HALF
	localparam logic [2:0] MQ_HALF = 3'h3;
	localparam logic [2:0] MQ_LAST = 3'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_END = 4'h9;
	localparam logic [4:0] TEN_PREFIX = 5'h1E;
	typedef enum logic [2:0] {
		TBA_IDLE = 3'h0, TBA_START = 3'h1, TBA_BITS = 3'h3, TBA_HOLD = 3'h2, TBA_STOP = 3'h6
	} tba_state_t;
	typedef enum logic [1:0] {
		TBA_NONE = 2'h0, TBA_MST = 2'h1, TBA_SRX = 2'h3, TBA_STX = 2'h2
	} tba_role_t;
	typedef enum logic [1:0] {
		TBA_ADR1 = 2'h0, TBA_ADR2 = 2'h1, TBA_DATA = 2'h3
	} tba_phase_t;
endpackage

// ---- hw/tba_i2c.sv ----
// two-wire controller: address matching, acknowledge and status flags
// Function
// - ten_bit_address_enable at control bit 10 selects 10-bit or 7-bit slave addressing.
// - as master in 10-bit mode, never acknowledge our own address command.
// - own address command raises only the master event, never a slave event.
// - 10-bit slave follows reserved-address rules whatever own A7:A1 holds.
// - every slave address ack with slave event copies byte and sets receive-full.
// - status bit 8 sets only when the whole 10-bit own address matched.
// - collision flag at status bit 10 clears by word write zero, not low-byte writes.
// - transmit-full flag bit 0 clears when sending proceeds, also on early collision.
// - slave sets ack status on master NACK; start or stop never clears it.
// - data-versus-address flag shows data once a slave data frame runs.
`timescale 1ns/1ps
module tba_i2c (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [4:0]  adr_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	input  wire logic        we_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	output logic             ack_o,
	input  wire logic        link_clk_i,
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe_o,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o
);
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
		logic        en;
		logic        ten;
		logic [9:0]  own;
		logic [7:0]  txb;
		logic        transmit_buffer_full_flag;
		logic        receive_buffer_full_flag;
		logic        bus_collision_flag;
		logic        mev;
		logic        sev;
		logic [7:0]  rcv;
		logic        pend;
		logic        p_tx;
		logic        p_st;
		logic        p_sp;
		logic        req;
		logic [22:0] snap;
		logic [4:0]  e1;
		logic [4:0]  e2;
		logic [4:0]  e3;
		logic [3:0]  l1;
		logic [3:0]  l2;
		logic        a1;
		logic        a2;
	} tba_bus_t;
	typedef struct packed {
		tba_pkg::tba_state_t st;
		tba_pkg::tba_role_t  role;
		tba_pkg::tba_phase_t ph;
		logic [3:0]  bcnt;
		logic [7:0]  sh;
		logic [2:0]  q;
		logic        sda_oe;
		logic        scl_oe;
		logic [7:0]  rx;
		logic        ten_bit_match_flag;
		logic        da;
		logic        rw;
		logic        acks;
		logic        nack;
		logic        busy;
		logic [4:0]  t;
		logic        r1;
		logic        r2;
		logic        ackt;
		logic        en;
		logic        ten;
		logic [9:0]  own;
		logic [7:0]  txb;
		logic        tbf_l;
		logic        start_p;
		logic        stop_p;
		logic [1:0]  c1;
		logic [1:0]  c2;
		logic [1:0]  cp;
	} tba_link_t;

	tba_bus_t  b, next_b;
	tba_link_t lk, next_lk;
	logic [1:0] lrst;
	logic       scl_v, sda_v, rise, fall, stc, spc;

	function automatic logic hit_reg(input logic [4:0] adr, input logic [4:0] off);
		hit_reg = (adr[4:2] == off[4:2]);
	endfunction

	assign scl_v = lk.c2[1];
	assign sda_v = lk.c2[0];
	assign rise  = scl_v & ~lk.cp[1];
	assign fall  = ~scl_v & lk.cp[1];
	assign stc   = scl_v & lk.cp[1] & lk.cp[0] & ~sda_v;
	assign spc   = scl_v & lk.cp[1] & ~lk.cp[0] & sda_v;

	// ---------------- register side ----------------
	always_comb begin
		logic [4:0] ev;
		logic       hit;
		logic       wr;
		ev = b.e2 ^ b.e3;
		hit = cyc_i & stb_i & ~b.ack;
		wr = hit & we_i;
		next_b = b;
		next_b.ack = hit;
		next_b.e1 = lk.t;
		next_b.e2 = b.e1;
		next_b.e3 = b.e2;
		next_b.l1 = {lk.ten_bit_match_flag, lk.rw, lk.da, lk.acks};
		next_b.l2 = b.l1;
		next_b.a1 = lk.ackt;
		next_b.a2 = b.a1;
		next_b.dat = 32'h0000_0000;
		if (ev[tba_pkg::EV_TBF])
			next_b.transmit_buffer_full_flag = 1'b0;
		if (hit && !we_i) begin
			if (hit_reg(adr_i, tba_pkg::OFF_CTRL)) begin
				next_b.dat[tba_pkg::CTRL_EN] = b.en;
				next_b.dat[tba_pkg::CTRL_TEN] = b.ten;
			end else if (hit_reg(adr_i, tba_pkg::OFF_STATUS)) begin
				next_b.dat[tba_pkg::ST_ACKS] = b.l2[0];
				next_b.dat[tba_pkg::ST_SEV] = b.sev;
				next_b.dat[tba_pkg::ST_MEV] = b.mev;
				next_b.dat[tba_pkg::ST_BCL] = b.bus_collision_flag;
				next_b.dat[tba_pkg::ST_A10] = b.l2[3];
				next_b.dat[tba_pkg::ST_DA] = b.l2[1];
				next_b.dat[tba_pkg::ST_RW] = b.l2[2];
				next_b.dat[tba_pkg::ST_RBF] = b.receive_buffer_full_flag;
				next_b.dat[tba_pkg::ST_TBF] = b.transmit_buffer_full_flag;
			end else if (hit_reg(adr_i, tba_pkg::OFF_OWN)) begin
				next_b.dat[9:0] = b.own;
			end else if (hit_reg(adr_i, tba_pkg::OFF_TX)) begin
				next_b.dat[7:0] = b.txb;
			end else if (hit_reg(adr_i, tba_pkg::OFF_RX)) begin
				next_b.dat[7:0] = b.rcv;
				next_b.receive_buffer_full_flag = 1'b0;
			end
		end
		if (wr && hit_reg(adr_i, tba_pkg::OFF_CTRL)) begin
			if (sel_i[1]) begin
				next_b.en = dat_i[tba_pkg::CTRL_EN];
				next_b.ten = dat_i[tba_pkg::CTRL_TEN];
			end
			if (sel_i[0]) begin
				next_b.p_st = b.p_st | dat_i[tba_pkg::CTRL_START];
				next_b.p_sp = b.p_sp | dat_i[tba_pkg::CTRL_STOP];
			end
			next_b.pend = 1'b1;
		end
		if (wr && hit_reg(adr_i, tba_pkg::OFF_OWN)) begin
			if (sel_i[0])
				next_b.own[7:0] = dat_i[7:0];
			if (sel_i[1])
				next_b.own[9:8] = dat_i[9:8];
			next_b.pend = 1'b1;
		end
		if (wr && hit_reg(adr_i, tba_pkg::OFF_TX) && sel_i[0]) begin
			next_b.txb = dat_i[7:0];
			next_b.transmit_buffer_full_flag = 1'b1;
			next_b.p_tx = 1'b1;
			next_b.pend = 1'b1;
		end
		if (wr && hit_reg(adr_i, tba_pkg::OFF_STATUS) && sel_i[1]) begin
			next_b.bus_collision_flag = b.bus_collision_flag & dat_i[tba_pkg::ST_BCL];
			next_b.mev = b.mev & dat_i[tba_pkg::ST_MEV];
			next_b.sev = b.sev & dat_i[tba_pkg::ST_SEV];
		end
		// events after software clears, so a set in the same cycle wins
		if (ev[tba_pkg::EV_RX]) begin
			next_b.rcv = lk.rx;
			next_b.receive_buffer_full_flag = 1'b1;
		end
		if (ev[tba_pkg::EV_BCL])
			next_b.bus_collision_flag = 1'b1;
		if (ev[tba_pkg::EV_MEV])
			next_b.mev = 1'b1;
		if (ev[tba_pkg::EV_SEV])
			next_b.sev = 1'b1;
		// one snapshot in flight at a time; later writes merge into the next one
		if (b.pend && (b.req == b.a2)) begin
			next_b.snap = {next_b.en, next_b.ten, next_b.own, next_b.txb, next_b.p_tx, next_b.p_st, next_b.p_sp};
			next_b.req = ~b.req;
			next_b.pend = 1'b0;
			next_b.p_tx = 1'b0;
			next_b.p_st = 1'b0;
			next_b.p_sp = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			b <= '0;
		else
			b <= next_b;
	end

	// ---------------- link side ----------------
	always_comb begin
		logic ackon;
		logic acc;
		logic quit;
		logic coll;
		logic load;
		ackon = 1'b0;
		acc = 1'b0;
		quit = 1'b0;
		coll = 1'b0;
		load = 1'b0;
		next_lk = lk;
		next_lk.c1 = {scl_i, sda_i};
		next_lk.c2 = lk.c1;
		next_lk.cp = lk.c2;
		next_lk.r1 = b.req;
		next_lk.r2 = lk.r1;
		// snapshot words are stable while the toggle is outstanding
		if (lk.r2 != lk.ackt) begin
			{next_lk.en, next_lk.ten, next_lk.own, next_lk.txb} = b.snap[22:3];
			next_lk.tbf_l = lk.tbf_l | b.snap[2];
			next_lk.start_p = lk.start_p | b.snap[1];
			next_lk.stop_p = lk.stop_p | b.snap[0];
			next_lk.ackt = lk.r2;
		end
		if (stc)
			next_lk.busy = 1'b1;
		if (spc) begin
			next_lk.busy = 1'b0;
			next_lk.ten_bit_match_flag = 1'b0;
		end
		// decoder idle while we are master
		if (stc && lk.en && lk.role != tba_pkg::TBA_MST) begin
			next_lk.st = tba_pkg::TBA_BITS;
			next_lk.role = tba_pkg::TBA_SRX;
			next_lk.ph = tba_pkg::TBA_ADR1;
			next_lk.bcnt = 4'h0;
			next_lk.sda_oe = 1'b0;
			next_lk.da = 1'b0;
		end else if (spc && lk.role != tba_pkg::TBA_MST) begin
			next_lk.st = tba_pkg::TBA_IDLE;
			next_lk.role = tba_pkg::TBA_NONE;
			next_lk.sda_oe = 1'b0;
		end else begin
			case (lk.st)
				tba_pkg::TBA_IDLE: begin
					if (lk.en && lk.start_p && !lk.busy) begin
						next_lk.st = tba_pkg::TBA_START;
						next_lk.role = tba_pkg::TBA_MST;
						next_lk.sda_oe = 1'b1;
						next_lk.q = 3'h0;
						next_lk.start_p = 1'b0;
					end
				end
				tba_pkg::TBA_START: begin
					next_lk.q = lk.q + 3'h1;
					if (!scl_v)
						coll = 1'b1;
					else if (lk.q == tba_pkg::MQ_LAST) begin
						next_lk.scl_oe = 1'b1;
						next_lk.st = tba_pkg::TBA_BITS;
						next_lk.bcnt = tba_pkg::BIT_END;
						next_lk.q = 3'h0;
					end
				end
				tba_pkg::TBA_BITS: begin
					if (lk.role == tba_pkg::TBA_MST) begin
						// released clock held low by a slave stretches the bit
						if (!(lk.q == tba_pkg::MQ_LAST && !scl_v))
							next_lk.q = lk.q + 3'h1;
						next_lk.scl_oe = (next_lk.q <= tba_pkg::MQ_HALF);
					end
					if (rise) begin
						next_lk.bcnt = lk.bcnt + 4'h1;
						if (lk.bcnt < tba_pkg::BIT_ACK) begin
							next_lk.sh = {lk.sh[6:0], sda_v};
							if (lk.role == tba_pkg::TBA_MST && !lk.sda_oe && !sda_v)
								coll = 1'b1;
						end else if (lk.bcnt == tba_pkg::BIT_ACK) begin
							if (lk.role == tba_pkg::TBA_MST) begin
								next_lk.acks = sda_v;
								next_lk.t[tba_pkg::EV_MEV] = ~lk.t[tba_pkg::EV_MEV];
							end else if (lk.role == tba_pkg::TBA_STX) begin
								next_lk.acks = sda_v;
								next_lk.nack = sda_v;
							end
						end
					end
					if (fall && lk.bcnt == tba_pkg::BIT_ACK) begin
						if (lk.role != tba_pkg::TBA_SRX)
							next_lk.sda_oe = 1'b0;
						else if (lk.ph == tba_pkg::TBA_DATA)
							acc = 1'b1;
						else if (lk.ph == tba_pkg::TBA_ADR2) begin
							if (lk.sh == lk.own[7:0]) begin
								acc = 1'b1;
								next_lk.ten_bit_match_flag = 1'b1;
								next_lk.ph = tba_pkg::TBA_DATA;
							end else
								quit = 1'b1;
						end else if (lk.ten) begin
							// only the 11110xx prefix can hit
							if (lk.sh[7:3] == tba_pkg::TEN_PREFIX && lk.sh[2:1] == lk.own[9:8]
								&& (!lk.sh[0] || lk.ten_bit_match_flag)) begin
								next_lk.rw = lk.sh[0];
								if (lk.sh[0]) begin
									acc = 1'b1;
									next_lk.role = tba_pkg::TBA_STX;
									next_lk.nack = 1'b0;
									next_lk.ph = tba_pkg::TBA_DATA;
								end else begin
									ackon = 1'b1;
									next_lk.ph = tba_pkg::TBA_ADR2;
								end
							end else
								quit = 1'b1;
						end else if (lk.sh[7:1] == lk.own[6:0]) begin
							acc = 1'b1;
							next_lk.rw = lk.sh[0];
							next_lk.ph = tba_pkg::TBA_DATA;
							if (lk.sh[0]) begin
								next_lk.role = tba_pkg::TBA_STX;
								next_lk.nack = 1'b0;
							end
						end else
							quit = 1'b1;
					end else if (fall && lk.bcnt == tba_pkg::BIT_END) begin
						next_lk.bcnt = 4'h0;
						if (lk.role != tba_pkg::TBA_MST)
							next_lk.da = (lk.ph == tba_pkg::TBA_DATA);
						if (lk.role == tba_pkg::TBA_MST) begin
							if (lk.tbf_l)
								load = 1'b1;
							else
								next_lk.st = tba_pkg::TBA_HOLD;
						end else if (lk.role == tba_pkg::TBA_STX) begin
							if (lk.nack)
								quit = 1'b1;
							else
								load = 1'b1;
						end else
							next_lk.sda_oe = 1'b0;
					end else if (fall && lk.role != tba_pkg::TBA_SRX)
						next_lk.sda_oe = ~lk.sh[7];
				end
				tba_pkg::TBA_HOLD: begin
					next_lk.scl_oe = 1'b1;
					if (lk.tbf_l) begin
						load = 1'b1;
						next_lk.bcnt = 4'h0;
						next_lk.q = 3'h0;
						next_lk.st = tba_pkg::TBA_BITS;
					end else if (lk.stop_p) begin
						next_lk.sda_oe = 1'b1;
						next_lk.q = 3'h0;
						next_lk.stop_p = 1'b0;
						next_lk.st = tba_pkg::TBA_STOP;
					end
				end
				tba_pkg::TBA_STOP: begin
					next_lk.q = lk.q + 3'h1;
					if (lk.q == tba_pkg::MQ_HALF)
						next_lk.scl_oe = 1'b0;
					if (lk.q == tba_pkg::MQ_LAST) begin
						next_lk.sda_oe = 1'b0;
						next_lk.role = tba_pkg::TBA_NONE;
						next_lk.st = tba_pkg::TBA_IDLE;
					end
				end
				default: next_lk.st = tba_pkg::TBA_IDLE;
			endcase
		end
		if (acc) begin
			ackon = 1'b1;
			next_lk.rx = lk.sh;
			next_lk.t[tba_pkg::EV_RX] = ~lk.t[tba_pkg::EV_RX];
			next_lk.t[tba_pkg::EV_SEV] = ~lk.t[tba_pkg::EV_SEV];
		end
		if (ackon)
			next_lk.sda_oe = 1'b1;
		if (quit) begin
			next_lk.sda_oe = 1'b0;
			next_lk.role = tba_pkg::TBA_NONE;
			next_lk.st = tba_pkg::TBA_IDLE;
		end
		if (load) begin
			next_lk.sh = lk.tbf_l ? lk.txb : 8'hFF;
			next_lk.sda_oe = lk.tbf_l ? ~lk.txb[7] : 1'b0;
			next_lk.tbf_l = 1'b0;
			if (lk.tbf_l)
				next_lk.t[tba_pkg::EV_TBF] = ~lk.t[tba_pkg::EV_TBF];
		end
		if (coll) begin
			next_lk.t[tba_pkg::EV_BCL] = ~lk.t[tba_pkg::EV_BCL];
			if (lk.tbf_l)
				next_lk.t[tba_pkg::EV_TBF] = ~lk.t[tba_pkg::EV_TBF];
			next_lk.tbf_l = 1'b0;
			next_lk.sda_oe = 1'b0;
			next_lk.scl_oe = 1'b0;
			next_lk.role = tba_pkg::TBA_NONE;
			next_lk.st = tba_pkg::TBA_IDLE;
		end
	end

	// reset is brought into the link domain through two stages
	always_ff @(posedge link_clk_i) begin
		lrst <= {lrst[0], rst_i};
		if (lrst[1])
			lk <= '0;
		else
			lk <= next_lk;
	end

	assign dat_o    = b.dat;
	assign ack_o    = b.ack;
	assign scl_oe_o = lk.scl_oe;
	assign sda_oe_o = lk.sda_oe;
	// open-drain: only ever pull low
	assign scl_o    = 1'b0;
	assign sda_o    = 1'b0;
endmodule

// ---- dv/tba_i2c_assertions.sv ----
// port-level checks on the two-wire block
`timescale 1ns/1ps
module tba_i2c_assertions (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic [4:0]  adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        we_i,
	input wire logic [3:0]  sel_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        ack_o,
	input wire logic        link_clk_i,
	input wire logic        scl_i,
	input wire logic        scl_o,
	input wire logic        scl_oe_o,
	input wire logic        sda_i,
	input wire logic        sda_o,
	input wire logic        sda_oe_o
);
	sequence req_s; cyc_i && stb_i && !ack_o; endsequence
	sequence ans_s; ack_o ##1 !ack_o; endsequence
	ack_follows_req_a: assert property (@(posedge clk_i) disable iff (rst_i) req_s |=> ans_s)
		else $error("no one-cycle ack after request");
	ack_has_cause_a: assert property (@(posedge clk_i) disable iff (rst_i) $rose(ack_o) |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	idle_data_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) !ack_o |-> dat_o == 32'h0)
		else $error("read data outside ack");
	write_data_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) ack_o && we_i |-> dat_o == 32'h0)
		else $error("data returned on write");
	upper_half_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) ack_o |-> dat_o[31:16] == 16'h0)
		else $error("upper half not zero");
	rx_byte_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o && adr_i == tba_pkg::OFF_RX |-> dat_o[31:8] == 24'h0) else $error("receive byte too wide");
	cmd_bits_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o && adr_i == tba_pkg::OFF_CTRL |-> dat_o[1:0] == 2'h0) else $error("command bits read back");
	pins_open_drain_a: assert property (@(posedge link_clk_i) disable iff (rst_i) !scl_o && !sda_o)
		else $error("pin driven high");
	scl_low_hold_a: assert property (@(posedge link_clk_i) disable iff (rst_i) $rose(scl_oe_o) |=> scl_oe_o[*3])
		else $error("clock low phase too short");
	scl_high_hold_a: assert property (@(posedge link_clk_i) disable iff (rst_i) $fell(scl_oe_o) |=> !scl_oe_o[*3])
		else $error("clock high phase too short");
endmodule
bind tba_i2c tba_i2c_assertions chk (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
	.dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
	.link_clk_i(link_clk_i), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_i),
	.sda_o(sda_o), .sda_oe_o(sda_oe_o));

// ---- dv/tba_peer.sv ----
// behavioural far-side party on the two-wire bus
`timescale 1ns/1ps
module tba_peer (
	input  wire logic lclk_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      scl_oe_o,
	output logic      sda_oe_o
);
	initial begin
		scl_oe_o = 1'b0;
		sda_oe_o = 1'b0;
	end
	task automatic hb;
		repeat (4) @(posedge lclk_i);
	endtask
	// holding the clock low provokes a collision on the device's start
	task automatic hold(input logic v);
		@(posedge lclk_i);
		scl_oe_o <= v;
	endtask
	task automatic start;
		sda_oe_o <= 1'b1;
		hb();
		scl_oe_o <= 1'b1;
		hb();
	endtask
	// ack is sampled late in the high half, after the slave had time to pull
	task automatic put(input logic [7:0] b, output logic ak);
		for (int i = 7; i >= 0; i--) begin
			sda_oe_o <= !b[i];
			hb();
			scl_oe_o <= 1'b0;
			hb();
			scl_oe_o <= 1'b1;
		end
		sda_oe_o <= 1'b0;
		hb();
		scl_oe_o <= 1'b0;
		hb();
		ak = !sda_i;
		scl_oe_o <= 1'b1;
	endtask
	// repeated start: free both lines, then a start from the idle-high state
	task automatic restart;
		sda_oe_o <= 1'b0;
		hb();
		scl_oe_o <= 1'b0;
		hb();
		start();
	endtask
	// master read: sample each bit late in the high half, then ack or nack
	task automatic get(output logic [7:0] b, input logic nak);
		sda_oe_o <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			hb();
			scl_oe_o <= 1'b0;
			hb();
			b[i] = sda_i;
			scl_oe_o <= 1'b1;
		end
		sda_oe_o <= !nak;
		hb();
		scl_oe_o <= 1'b0;
		hb();
		scl_oe_o <= 1'b1;
	endtask
	task automatic stop;
		sda_oe_o <= 1'b1;
		hb();
		scl_oe_o <= 1'b0;
		hb();
		sda_oe_o <= 1'b0;
		hb();
	endtask
endmodule

// ---- dv/tba_i2c_tb.sv ----
// self-checking bench for the two-wire addressing and status block
`timescale 1ns/1ps
module tba_i2c_tb;
	logic        clk_i = 1'b0, lclk = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
	logic [4:0]  adr_i = 5'h00;
	logic [3:0]  sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o, rd;
	logic        ack_o, scl_o, scl_oe_o, sda_o, sda_oe_o, p_scl, p_sda, ak;
	logic [7:0]  rb;
	int          n_errors = 0, n_tests = 0, ticks = 0;
	wire         scl = !(scl_oe_o || p_scl);
	wire         sda = !(sda_oe_o || p_sda);
	always #5 clk_i = !clk_i;
	initial begin
		#37;
		forever #80 lclk = !lclk;
	end
	tba_i2c uut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i),
		.sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .link_clk_i(lclk), .scl_i(scl),
		.scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o));
	tba_peer peer (.lclk_i(lclk), .scl_i(scl), .sda_i(sda), .scl_oe_o(p_scl), .sda_oe_o(p_sda));
	task automatic results;
		$display("errors %0d of %0d checks", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		ticks <= ticks + 1;
		if (ticks == 40000) begin
			n_errors++;
			results();
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			n_errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wb(input logic [4:0] a, input logic w, input logic [3:0] s, input logic [31:0] d);
		@(posedge clk_i);
		adr_i <= a;
		we_i <= w;
		sel_i <= s;
		dat_i <= d;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	// link events need a few bus clocks to land in the status word
	task automatic st;
		repeat (4) @(posedge clk_i);
		wb(tba_pkg::OFF_STATUS, 1'b0, 4'hF, 32'h0);
	endtask
	task automatic rx;
		wb(tba_pkg::OFF_RX, 1'b0, 4'hF, 32'h0);
	endtask
	task automatic poll(input int b);
		repeat (2000) begin
			st();
			if (rd[b] === 1'b1) break;
		end
	endtask
	task automatic cfg(input logic [31:0] own, input logic [31:0] ctl);
		wb(tba_pkg::OFF_STATUS, 1'b1, 4'h3, 32'h0);
		wb(tba_pkg::OFF_OWN, 1'b1, 4'h3, own);
		wb(tba_pkg::OFF_CTRL, 1'b1, 4'h3, ctl);
		repeat (8) @(posedge lclk);
	endtask
	task automatic t_reset;
		st();
		chk(rd, 32'h0);
		wb(tba_pkg::OFF_OWN, 1'b0, 4'hF, 32'h0);
		chk(rd, 32'h0);
		wb(5'h14, 1'b1, 4'hF, 32'hFFFF);
		wb(5'h14, 1'b0, 4'hF, 32'h0);
		chk(rd, 32'h0);
	endtask
	task automatic t_slave7;
		cfg(32'h55, 32'h8000);
		peer.start();
		peer.put(8'hAA, ak);
		chk(ak, 1'b1);
		st();
		chk(rd & 32'h2022, 32'h2002);
		rx();
		chk(rd, 32'hAA);
		peer.put(8'h3C, ak);
		st();
		chk(rd & 32'h22, 32'h22);
		rx();
		chk(rd, 32'h3C);
		peer.stop();
	endtask
	task automatic t_slave10;
		cfg(32'h10A, 32'h8400);
		wb(tba_pkg::OFF_CTRL, 1'b0, 4'hF, 32'h0);
		chk(rd, 32'h8400);
		peer.start();
		peer.put(8'h14, ak);
		chk(ak, 1'b0);
		peer.stop();
		peer.start();
		peer.put(8'hF2, ak);
		chk(ak, 1'b1);
		st();
		chk(rd & 32'h2102, 32'h0);
		peer.put(8'h0A, ak);
		chk(ak, 1'b1);
		st();
		chk(rd & 32'h2102, 32'h2102);
		rx();
		chk(rd, 32'h0A);
		// 10-bit read after a repeated start, ended by a master nack
		wb(tba_pkg::OFF_TX, 1'b1, 4'h1, 32'hC3);
		peer.restart();
		peer.put(8'hF3, ak);
		chk(ak, 1'b1);
		st();
		chk(rd[15], 1'b0);
		peer.get(rb, 1'b1);
		chk(rb, 32'hC3);
		st();
		chk(rd & 32'h8101, 32'h8100);
		peer.stop();
		st();
		chk(rd & 32'h8100, 32'h8000);
		peer.start();
		st();
		chk(rd[15], 1'b1);
		peer.stop();
	endtask
	// own top bits equal the target's on purpose, so a self-ack would show
	task automatic t_master;
		cfg(32'h3A5, 32'h8400);
		wb(tba_pkg::OFF_TX, 1'b1, 4'h1, 32'hF6);
		st();
		chk(rd[0], 1'b1);
		wb(tba_pkg::OFF_CTRL, 1'b1, 4'h3, 32'h8401);
		poll(tba_pkg::ST_MEV);
		chk(rd & 32'hB101, 32'h9000);
		wb(tba_pkg::OFF_CTRL, 1'b1, 4'h3, 32'h8402);
		repeat (16) @(posedge lclk);
	endtask
	task automatic t_collide;
		cfg(32'h0, 32'h8000);
		peer.hold(1'b1);
		wb(tba_pkg::OFF_TX, 1'b1, 4'h1, 32'h55);
		wb(tba_pkg::OFF_CTRL, 1'b1, 4'h3, 32'h8001);
		poll(tba_pkg::ST_BCL);
		chk(rd & 32'h401, 32'h400);
		peer.hold(1'b0);
		wb(tba_pkg::OFF_STATUS, 1'b1, 4'h1, 32'h0);
		st();
		chk(rd[10], 1'b1);
		wb(tba_pkg::OFF_STATUS, 1'b1, 4'h3, 32'hFBFF);
		st();
		chk(rd[10], 1'b0);
	endtask
	// reset is held long enough for the link side to see it too
	initial begin
		repeat (70) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_slave7();
		t_slave10();
		t_master();
		t_collide();
		results();
	end
endmodule
